// ### include/pfs_pkg.sv
`default_nettype none
package pfs_pkg;
  // ****************************************************************
  // bus and data widths
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int ADC_W = 12;
  localparam int NUM_CH = 6;
  localparam int GAP_W = 10;
  localparam int MINBLANK_W = 7;
  localparam int DELAY_W = 10;
  localparam int PERSIST_W = 11;
  localparam int RESUME_W = 13;
  localparam int FILT_SHIFT = 9;
  localparam int FILT_W = ADC_W + FILT_SHIFT;
  localparam int MOTOR_GATE_N = 6;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_PFC_ENABLE = 16'h819C;
  localparam logic [ADDR_W-1:0] OFS_PFC_MIN_PULSE = 16'h81A8;
  localparam logic [ADDR_W-1:0] OFS_BLANK_DC_OFFSET = 16'h81AA;
  localparam logic [ADDR_W-1:0] OFS_BLANK_GAP = 16'h81AC;
  localparam logic [ADDR_W-1:0] OFS_MOTOR_ISCALE = 16'h8246;
  localparam logic [ADDR_W-1:0] OFS_AC_OV_THR = 16'h8270;
  localparam logic [ADDR_W-1:0] OFS_AC_UV_THR = 16'h8272;
  localparam logic [ADDR_W-1:0] OFS_PFC_DUTY = 16'h827C;
  localparam logic [ADDR_W-1:0] OFS_AC_UV_TIME = 16'h82EC;
  localparam logic [ADDR_W-1:0] OFS_AC_OV_TIME = 16'h82EE;
  localparam logic [ADDR_W-1:0] OFS_AC_RESUME = 16'h82F0;
  localparam logic [ADDR_W-1:0] OFS_CH0 = 16'h82F4;
  localparam logic [ADDR_W-1:0] OFS_CH1 = 16'h82F6;
  localparam logic [ADDR_W-1:0] OFS_CH2 = 16'h82F8;
  localparam logic [ADDR_W-1:0] OFS_CH3 = 16'h82FA;
  localparam logic [ADDR_W-1:0] OFS_CH4 = 16'h82FC;
  localparam logic [ADDR_W-1:0] OFS_MIN_BLANK = 16'h832A;
  localparam logic [ADDR_W-1:0] OFS_PFC_GATE_DLY = 16'h832E;
  localparam logic [ADDR_W-1:0] OFS_HALF_REF = 16'h8332;
  localparam logic [ADDR_W-1:0] OFS_CH5 = 16'h8334;
  localparam logic [ADDR_W-1:0] OFS_AC_VSCALE = 16'h834E;
  localparam logic [ADDR_W-1:0] OFS_DC_VSCALE = 16'h8354;
  localparam logic [ADDR_W-1:0] OFS_PFC_ISCALE = 16'h83AE;
  localparam logic [ADDR_W-1:0] OFS_MOTOR_CFG = 16'h8400;
  localparam logic [ADDR_W-1:0] OFS_GATE_SNAP = 16'hF234;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int CFG_LEG_SHUNT_BIT = 0;
  localparam int CFG_COMP_SEL_BIT = 9;
  localparam int SNAP_MOTOR_LSB = 6;
  localparam int SNAP_PFC_BIT = 12;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DUTY_FULL = 16'hFFFF;
  localparam logic [ADC_W-1:0] HALF_REF_RESET = 12'h800;
  localparam logic [FILT_W-1:0] FILT_ACC_INIT = {HALF_REF_RESET, 9'h000};

  typedef enum logic [1:0] {PFS_IDLE, PFS_RUN, PFS_FAULT, PFS_RESUME} pfs_state_t;
endpackage : pfs_pkg
`default_nettype wire

// ### rtl/pfs_delay_pulse.sv
`default_nettype none
// one-shot: o_pulse is high for one cycle, i_delay+2 cycles after i_start
module pfs_delay_pulse
  import pfs_pkg::*;
#(
  parameter int W = DELAY_W
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic [W-1:0] i_delay,
  output logic o_pulse
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic pulse;
  } pfs_dly_st_t;

  pfs_dly_st_t st_reg;
  pfs_dly_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.pulse = 1'b0;
    // a new edge restarts the wait, so only the latest edge is sampled
    if (i_start) begin
      st_next.cnt = i_delay;
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      if (st_reg.cnt == '0) begin
        st_next.pulse = 1'b1;
        st_next.busy = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_pulse = st_reg.pulse;
endmodule : pfs_delay_pulse
`default_nettype wire

// ### rtl/pfs_regs.sv
// Summary of operation
// - one hysteresis gap serves the dc-bus blanking and AC overvoltage comparisons.
// - once blanking sets, it holds for at least min_blanking_time PWM periods.
// - PFC duty equals pfc_duty_command over 65535; full scale is always on.
// - current sampling instants trail the gate edges by pfc_gate_delay plus one clocks.
// - duty commands shorter than pfc_min_pulse_width clocks give no pulse.
// - AC overvoltage declared after sample stays above threshold for persist count.
// - AC undervoltage declared after sample stays below threshold for persist count.
// - PFC resumes only after ac_resume_delay PWM periods of healthy AC.
// - gate snapshot reports motor gates in bits 6..11, PFC gate bit 12.
// - analog channels read as 12-bit unsigned values, upper bits zero.
// - config bit 9 selects raw or compensated converter results.
// - with leg-shunt sensing, channel 5 carries downsampled V-phase current.
// - half-reference filter adds (input minus output) over 512 each sample.
// - the filter state starts at 2048 times 512; the register reads 2048 after reset.
// - half-reference comes from the internal seventh converter channel.
// - PFC PWM stops when AC exceeds half DC bus minus offset minus gap.
// - pfc_master_enable starts PFC PWM at one and stops it at zero.
`default_nettype none
module pfs_regs
  import pfs_pkg::*;
#(
  parameter logic [DATA_W-1:0] PWM_PERIOD = DUTY_FULL
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_pwm_tick,
  input wire logic [ADC_W-1:0] i_ac_voltage_sample,
  input wire logic i_adc_valid,
  input wire logic [NUM_CH-1:0][ADC_W-1:0] i_adc_raw,
  input wire logic [NUM_CH-1:0][ADC_W-1:0] i_adc_comp,
  input wire logic [ADC_W-1:0] i_vphase_current_ds,
  input wire logic i_internal_reference_valid,
  input wire logic [ADC_W-1:0] i_internal_reference_channel,
  input wire logic [MOTOR_GATE_N-1:0] i_motor_gates,
  output logic o_pfc_switch_gate,
  output logic o_sample_on,
  output logic o_sample_off,
  output logic o_dcbus_blanking_flag,
  output logic o_ac_overvoltage,
  output logic o_ac_undervoltage,
  output logic o_pfc_running
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic enable;
    logic [DATA_W-1:0] min_pulse, gap, blank_ofs, motor_iscale, ov_thr, uv_thr;
    logic [DATA_W-1:0] duty_cmd, uv_time, ov_time, resume_dly, min_blank, gate_dly;
    logic [DATA_W-1:0] vac_scale, vdc_scale, pfc_iscale, cfg;
    logic [DATA_W-1:0] sh_min_pulse, sh_gap, sh_blank_ofs, sh_ov_thr, sh_uv_thr;
    logic [DATA_W-1:0] sh_duty, sh_uv_time, sh_ov_time, sh_resume, sh_min_blank, sh_gate_dly;
    logic [NUM_CH-1:0][ADC_W-1:0] ch;
    logic [FILT_W-1:0] filt_acc;
    logic [DATA_W-1:0] snap;
    logic [DATA_W-1:0] pwm_cnt;
    logic [DATA_W-1:0] duty_eff;
    logic gate;
    logic [MINBLANK_W:0] blank_cnt;
    logic blank;
    logic [PERSIST_W:0] ov_cnt;
    logic [PERSIST_W:0] uv_cnt;
    logic ov;
    logic uv;
    logic [RESUME_W-1:0] resume_cnt;
    pfs_state_t state;
    logic run;
    logic [DATA_W-1:0] rdata;
  } pfs_st_t;

  pfs_st_t st_reg;
  pfs_st_t st_next;
  logic gate_rise;
  logic gate_fall;
  logic signed [14:0] thr_set;
  logic signed [14:0] thr_clr;
  logic signed [14:0] vac_s;
  logic vac_above_ov;
  logic vac_below_uv;
  logic ov_released;
  logic [NUM_CH-1:0][ADC_W-1:0] ch_sel;

  // ****************************************************************
  // reset value of the whole state
  // ****************************************************************
  function automatic pfs_st_t pfs_reset_state();
    pfs_st_t s;
    s = '0;
    s.filt_acc = FILT_ACC_INIT;
    s.state = PFS_IDLE;
    return s;
  endfunction : pfs_reset_state

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    // blanking thresholds in signed counts so a large offset cannot wrap
    vac_s = signed'({3'h0, i_ac_voltage_sample});
    thr_set = signed'({4'h0, st_reg.ch[0][ADC_W-1:1]})
      - signed'({5'h00, st_reg.sh_blank_ofs[GAP_W-1:0]})
      - signed'({5'h00, st_reg.sh_gap[GAP_W-1:0]});
    thr_clr = thr_set - signed'({5'h00, st_reg.sh_gap[GAP_W-1:0]});
    vac_above_ov = i_ac_voltage_sample > st_reg.sh_ov_thr[ADC_W-1:0];
    vac_below_uv = i_ac_voltage_sample < st_reg.sh_uv_thr[ADC_W-1:0];
    ov_released = ({2'h0, i_ac_voltage_sample} + {4'h0, st_reg.sh_gap[GAP_W-1:0]})
      < {2'h0, st_reg.sh_ov_thr[ADC_W-1:0]};

    // register writes; read-only offsets are ignored
    if (i_wr) begin
      case (i_addr)
        OFS_PFC_ENABLE: st_next.enable = i_wdata[0];
        OFS_PFC_MIN_PULSE: st_next.min_pulse = i_wdata;
        OFS_BLANK_DC_OFFSET: st_next.blank_ofs = i_wdata;
        OFS_BLANK_GAP: st_next.gap = i_wdata;
        OFS_MOTOR_ISCALE: st_next.motor_iscale = i_wdata;
        OFS_AC_OV_THR: st_next.ov_thr = i_wdata;
        OFS_AC_UV_THR: st_next.uv_thr = i_wdata;
        OFS_PFC_DUTY: st_next.duty_cmd = i_wdata;
        OFS_AC_UV_TIME: st_next.uv_time = i_wdata;
        OFS_AC_OV_TIME: st_next.ov_time = i_wdata;
        OFS_AC_RESUME: st_next.resume_dly = i_wdata;
        OFS_MIN_BLANK: st_next.min_blank = i_wdata;
        OFS_PFC_GATE_DLY: st_next.gate_dly = i_wdata;
        OFS_AC_VSCALE: st_next.vac_scale = i_wdata;
        OFS_DC_VSCALE: st_next.vdc_scale = i_wdata;
        OFS_PFC_ISCALE: st_next.pfc_iscale = i_wdata;
        OFS_MOTOR_CFG: st_next.cfg = i_wdata;
        default: st_next.cfg = st_reg.cfg;
      endcase
    end

    // read data stands in the cycle after the strobe only
    st_next.rdata = REG_RESET;
    if (i_rd) begin
      case (i_addr)
        OFS_PFC_ENABLE: st_next.rdata = {15'h0000, st_reg.enable};
        OFS_PFC_MIN_PULSE: st_next.rdata = st_reg.min_pulse;
        OFS_BLANK_DC_OFFSET: st_next.rdata = st_reg.blank_ofs;
        OFS_BLANK_GAP: st_next.rdata = st_reg.gap;
        OFS_MOTOR_ISCALE: st_next.rdata = st_reg.motor_iscale;
        OFS_AC_OV_THR: st_next.rdata = st_reg.ov_thr;
        OFS_AC_UV_THR: st_next.rdata = st_reg.uv_thr;
        OFS_PFC_DUTY: st_next.rdata = st_reg.duty_cmd;
        OFS_AC_UV_TIME: st_next.rdata = st_reg.uv_time;
        OFS_AC_OV_TIME: st_next.rdata = st_reg.ov_time;
        OFS_AC_RESUME: st_next.rdata = st_reg.resume_dly;
        OFS_CH0: st_next.rdata = {4'h0, st_reg.ch[0]};
        OFS_CH1: st_next.rdata = {4'h0, st_reg.ch[1]};
        OFS_CH2: st_next.rdata = {4'h0, st_reg.ch[2]};
        OFS_CH3: st_next.rdata = {4'h0, st_reg.ch[3]};
        OFS_CH4: st_next.rdata = {4'h0, st_reg.ch[4]};
        OFS_CH5: st_next.rdata = {4'h0, st_reg.ch[5]};
        OFS_MIN_BLANK: st_next.rdata = st_reg.min_blank;
        OFS_PFC_GATE_DLY: st_next.rdata = st_reg.gate_dly;
        OFS_HALF_REF: st_next.rdata = {4'h0, st_reg.filt_acc[FILT_W-1:FILT_SHIFT]};
        OFS_AC_VSCALE: st_next.rdata = st_reg.vac_scale;
        OFS_DC_VSCALE: st_next.rdata = st_reg.vdc_scale;
        OFS_PFC_ISCALE: st_next.rdata = st_reg.pfc_iscale;
        OFS_MOTOR_CFG: st_next.rdata = st_reg.cfg;
        OFS_GATE_SNAP: st_next.rdata = st_reg.snap;
        default: st_next.rdata = REG_RESET;
      endcase
    end

    // parameters move into the working copy only at a motor PWM start
    if (i_pwm_tick) begin
      st_next.sh_min_pulse = st_reg.min_pulse;
      st_next.sh_gap = st_reg.gap;
      st_next.sh_blank_ofs = st_reg.blank_ofs;
      st_next.sh_ov_thr = st_reg.ov_thr;
      st_next.sh_uv_thr = st_reg.uv_thr;
      st_next.sh_duty = st_reg.duty_cmd;
      st_next.sh_uv_time = st_reg.uv_time;
      st_next.sh_ov_time = st_reg.ov_time;
      st_next.sh_resume = st_reg.resume_dly;
      st_next.sh_min_blank = st_reg.min_blank;
      st_next.sh_gate_dly = st_reg.gate_dly;
    end

    // converter results
    for (int i = 0; i < NUM_CH; i++) begin
      ch_sel[i] = st_reg.cfg[CFG_COMP_SEL_BIT] ? i_adc_comp[i] : i_adc_raw[i];
    end
    if (st_reg.cfg[CFG_LEG_SHUNT_BIT]) begin
      ch_sel[NUM_CH-1] = i_vphase_current_ds;
    end
    if (i_adc_valid) begin
      st_next.ch = ch_sel;
    end
    if (i_internal_reference_valid) begin
      st_next.filt_acc = st_reg.filt_acc + {9'h000, i_internal_reference_channel}
        - {9'h000, st_reg.filt_acc[FILT_W-1:FILT_SHIFT]};
    end
    st_next.snap = REG_RESET;
    st_next.snap[SNAP_MOTOR_LSB +: MOTOR_GATE_N] = i_motor_gates;
    st_next.snap[SNAP_PFC_BIT] = st_reg.gate;

    // dc-bus blanking with minimum hold
    if (i_pwm_tick && st_reg.blank_cnt != '0) begin
      st_next.blank_cnt = st_reg.blank_cnt - 1'b1;
    end
    if (vac_s > thr_set) begin
      st_next.blank = 1'b1;
      if (!st_reg.blank) begin
        // one extra tick: a set just before a tick must still hold whole periods
        st_next.blank_cnt = {1'b0, st_reg.sh_min_blank[MINBLANK_W-1:0]} + 1'b1;
      end
    end else if (st_reg.blank && st_reg.blank_cnt == '0 && vac_s < thr_clr) begin
      st_next.blank = 1'b0;
    end

    // AC persistence checks, counted in motor PWM periods
    if (i_pwm_tick) begin
      if (vac_above_ov) begin
        if (st_reg.ov_cnt < {1'b0, st_reg.sh_ov_time[PERSIST_W-1:0]}) begin
          st_next.ov_cnt = st_reg.ov_cnt + 1'b1;
        end else begin
          st_next.ov = 1'b1;
        end
      end else begin
        st_next.ov_cnt = '0;
      end
      if (vac_below_uv) begin
        if (st_reg.uv_cnt < {1'b0, st_reg.sh_uv_time[PERSIST_W-1:0]}) begin
          st_next.uv_cnt = st_reg.uv_cnt + 1'b1;
        end else begin
          st_next.uv = 1'b1;
        end
      end else begin
        st_next.uv_cnt = '0;
        st_next.uv = 1'b0;
      end
      if (ov_released) begin
        st_next.ov = 1'b0;
      end
    end

    // supervision state machine
    case (st_reg.state)
      PFS_IDLE: begin
        if (st_reg.enable) begin
          st_next.state = PFS_RUN;
        end
      end
      PFS_RUN: begin
        if (!st_reg.enable) begin
          st_next.state = PFS_IDLE;
        end else if (st_reg.ov || st_reg.uv) begin
          st_next.state = PFS_FAULT;
        end
      end
      PFS_FAULT: begin
        st_next.resume_cnt = '0;
        if (!st_reg.enable) begin
          st_next.state = PFS_IDLE;
        end else if (!st_reg.ov && !st_reg.uv) begin
          st_next.state = PFS_RESUME;
        end
      end
      PFS_RESUME: begin
        if (!st_reg.enable) begin
          st_next.state = PFS_IDLE;
        end else if (st_reg.ov || st_reg.uv) begin
          st_next.state = PFS_FAULT;
        end else if (st_reg.resume_cnt >= st_reg.sh_resume[RESUME_W-1:0]) begin
          st_next.state = PFS_RUN;
        end else if (i_pwm_tick) begin
          st_next.resume_cnt = st_reg.resume_cnt + 1'b1;
        end
      end
      default: st_next.state = PFS_IDLE;
    endcase
    st_next.run = (st_next.state == PFS_RUN);

    // PFC PWM carrier; the duty is latched once per carrier period
    if (st_reg.pwm_cnt >= PWM_PERIOD - 1'b1) begin
      st_next.pwm_cnt = '0;
    end else begin
      st_next.pwm_cnt = st_reg.pwm_cnt + 1'b1;
    end
    if (st_reg.pwm_cnt == '0) begin
      st_next.duty_eff = (st_reg.sh_duty < st_reg.sh_min_pulse) ? '0 : st_reg.sh_duty;
    end
    st_next.gate = (st_reg.state == PFS_RUN) && !st_reg.blank
      && (st_reg.pwm_cnt < st_reg.duty_eff);
  end

  assign gate_rise = st_next.gate && !st_reg.gate;
  assign gate_fall = !st_next.gate && st_reg.gate;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= pfs_reset_state();
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // sampling instants trail each gate edge
  // ****************************************************************
  pfs_delay_pulse #(.W(DELAY_W)) u_sample_on (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_start(gate_rise),
    .i_delay(st_reg.sh_gate_dly[DELAY_W-1:0]),
    .o_pulse(o_sample_on)
  );

  pfs_delay_pulse #(.W(DELAY_W)) u_sample_off (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_start(gate_fall),
    .i_delay(st_reg.sh_gate_dly[DELAY_W-1:0]),
    .o_pulse(o_sample_off)
  );

  assign o_rdata = st_reg.rdata;
  assign o_pfc_switch_gate = st_reg.gate;
  assign o_dcbus_blanking_flag = st_reg.blank;
  assign o_ac_overvoltage = st_reg.ov;
  assign o_ac_undervoltage = st_reg.uv;
  assign o_pfc_running = st_reg.run;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  a_gate_below_duty: assert property (
    o_pfc_switch_gate |-> $past(st_reg.pwm_cnt) < $past(st_reg.duty_eff))
    else $error("gate high beyond duty");
  a_min_pulse_drop: assert property (
    st_reg.pwm_cnt == '0 && st_reg.sh_duty < st_reg.sh_min_pulse |=> st_reg.duty_eff == '0)
    else $error("short pulse not dropped");
  a_sample_delay_zero: assert property (
    $rose(o_pfc_switch_gate) && $past(st_reg.sh_gate_dly[DELAY_W-1:0]) == '0
    |=> o_sample_on)
    else $error("sample not at gate edge");
  a_ov_persist: assert property (
    $rose(o_ac_overvoltage) |-> $past(vac_above_ov) && $past(i_pwm_tick))
    else $error("overvoltage without persistence");
  a_uv_persist: assert property (
    $rose(o_ac_undervoltage) |-> $past(vac_below_uv) && $past(i_pwm_tick))
    else $error("undervoltage without persistence");
  a_resume_wait: assert property (
    $past(st_reg.state) == PFS_RESUME && st_reg.state == PFS_RUN
    |-> $past(st_reg.resume_cnt) >= $past(st_reg.sh_resume[RESUME_W-1:0]))
    else $error("resumed early");
  a_blank_hold: assert property (
    o_dcbus_blanking_flag && st_reg.blank_cnt != '0 |=> o_dcbus_blanking_flag)
    else $error("blanking released early");
  a_blank_gate_off: assert property (
    o_dcbus_blanking_flag |=> !o_pfc_switch_gate)
    else $error("gate during blanking");
  a_enable_stop: assert property (
    !st_reg.enable [*2] |-> ##1 !o_pfc_switch_gate)
    else $error("gate while disabled");
  a_gate_snapshot: assert property (
    1'b1 |=> st_reg.snap[SNAP_MOTOR_LSB +: MOTOR_GATE_N] == $past(i_motor_gates))
    else $error("gate snapshot stale");
  a_filter_step: assert property (
    i_internal_reference_valid |=> st_reg.filt_acc == $past(st_reg.filt_acc)
      + {9'h000, $past(i_internal_reference_channel)}
      - {9'h000, $past(st_reg.filt_acc[FILT_W-1:FILT_SHIFT])})
    else $error("filter step wrong");

  c_gate_pulse: cover property ($rose(o_pfc_switch_gate) ##[1:8] o_sample_on);
  c_ov_seen: cover property ($rose(o_ac_overvoltage));
  c_resume_run: cover property (st_reg.state == PFS_RESUME ##1 st_reg.state == PFS_RUN);
endmodule : pfs_regs
`default_nettype wire

// ### tb/pfs_plant_model.sv
`default_nettype none
module pfs_plant_model
  import pfs_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [ADC_W-1:0] i_dc,
  output logic o_tick,
  output logic [NUM_CH-1:0][ADC_W-1:0] o_raw,
  output logic [NUM_CH-1:0][ADC_W-1:0] o_comp,
  output logic [ADC_W-1:0] o_vph
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_reg;
  // ****************************************************************
  // motor pwm period of 8 clocks; converter results land on each tick
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg <= 3'h0;
      o_tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      o_tick <= (cnt_reg == 3'h7);
    end
  end
  // raw and compensated differ in the low byte on channels 1 to 5 so a wrong select shows
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      o_raw[i] = {4'(i), 8'h11};
      o_comp[i] = {4'(i), 8'h22};
    end
    o_raw[0] = i_dc;
    o_comp[0] = i_dc;
  end
  assign o_vph = 12'h5A5;
endmodule : pfs_plant_model
`default_nettype wire

// ### tb/pfs_regs_tb.sv
`default_nettype none
module pfs_regs_tb;
  import pfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] RW_OFS [14] = '{OFS_PFC_MIN_PULSE, OFS_BLANK_GAP, OFS_MOTOR_ISCALE,
    OFS_AC_OV_THR, OFS_AC_UV_THR, OFS_PFC_DUTY, OFS_AC_UV_TIME, OFS_AC_OV_TIME, OFS_AC_RESUME,
    OFS_MIN_BLANK, OFS_PFC_GATE_DLY, OFS_AC_VSCALE, OFS_DC_VSCALE, OFS_PFC_ISCALE};
  localparam logic [15:0] CH_OFS [6] = '{OFS_CH0, OFS_CH1, OFS_CH2, OFS_CH3, OFS_CH4, OFS_CH5};
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rv = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic [11:0] vac = 12'h100;
  logic [11:0] rch = 12'h800;
  logic [11:0] dc = 12'hFA0;
  logic [5:0] gates = 6'h00;
  logic [15:0] rdata;
  logic [11:0] vph;
  logic [NUM_CH-1:0][ADC_W-1:0] raw, comp;
  logic tick, gate, s_on, s_off, blank, ov, uv, run;
  int err_count = 0;
  int checks_done = 0;
  int cyc_n = 0;
  initial begin
    forever #20 mclk = ~mclk;
  end
  pfs_plant_model plant (.i_mclk(mclk), .i_arst_n(arst_n), .i_dc(dc), .o_tick(tick),
    .o_raw(raw), .o_comp(comp), .o_vph(vph));
  pfs_regs #(.PWM_PERIOD(16'h0010)) DUT (.i_mclk(mclk), .i_arst_n(arst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pwm_tick(tick),
    .i_ac_voltage_sample(vac), .i_adc_valid(tick), .i_adc_raw(raw), .i_adc_comp(comp),
    .i_vphase_current_ds(vph), .i_internal_reference_valid(rv),
    .i_internal_reference_channel(rch), .i_motor_gates(gates), .o_pfc_switch_gate(gate),
    .o_sample_on(s_on), .o_sample_off(s_off), .o_dcbus_blanking_flag(blank),
    .o_ac_overvoltage(ov), .o_ac_undervoltage(uv), .o_pfc_running(run));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wreg(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rchk(input string nm, input logic [15:0] a, input logic [15:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(nm, rdata, exp);
  endtask : rchk
  // waits a few clocks past the tick so its effect has landed
  task automatic tk(input int n);
    repeat (n) @(posedge tick);
    repeat (3) @(posedge mclk);
    #1;
  endtask : tk
  task automatic hi_cnt(output int n);
    n = 0;
    repeat (32) begin
      @(posedge mclk);
      #1;
      n += int'(gate === 1'b1);
    end
  endtask : hi_cnt
  // single steps only probe the recursion; no check relies on a settled value
  task automatic fstep(input logic [11:0] u, input logic [15:0] exp);
    @(posedge mclk);
    rv <= 1'b1;
    rch <= u;
    @(posedge mclk);
    rv <= 1'b0;
    rchk("half_ref_filter", OFS_HALF_REF, exp);
  endtask : fstep
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    rchk("half_ref_reset", OFS_HALF_REF, 16'h0800);
    wreg(OFS_HALF_REF, 16'h1234);
    rchk("half_ref_ro", OFS_HALF_REF, 16'h0800);
    rchk("unmapped", 16'h8000, 16'h0000);
    foreach (RW_OFS[i]) begin
      rchk("rw_reset", RW_OFS[i], 16'h0000);
      wreg(RW_OFS[i], 16'h0040 + 16'(i));
      rchk("rw_back", RW_OFS[i], 16'h0040 + 16'(i));
      wreg(RW_OFS[i], 16'h0000);
    end
  endtask : t_regs
  task automatic t_chan();
    logic [11:0] e;
    for (int m = 0; m < 3; m++) begin
      wreg(OFS_MOTOR_CFG, (m == 0) ? 16'h0000 : (m == 1) ? 16'h0200 : 16'h0201);
      tk(2);
      for (int c = 0; c < NUM_CH; c++) begin
        e = (m == 2 && c == 5) ? vph : (m == 0) ? raw[c] : comp[c];
        rchk("channel", CH_OFS[c], 16'(e));
      end
    end
    gates <= 6'h2D;
    rchk("gate_snapshot", OFS_GATE_SNAP, 16'h0B40);
  endtask : t_chan
  task automatic t_pwm();
    int n;
    wreg(OFS_AC_OV_THR, 16'h0FFF);
    wreg(OFS_PFC_GATE_DLY, 16'h0003);
    wreg(OFS_PFC_DUTY, DUTY_FULL);
    tk(2);
    wreg(OFS_PFC_ENABLE, 16'h0001);
    n = 0;
    while (gate !== 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    n = 0;
    while (s_on !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("sample_delay", 16'(n), 16'h0004);
    hi_cnt(n);
    chk("full_duty", 16'(n), 16'h0020);
    chk("running", 16'(run), 16'h0001);
    rchk("snapshot_pfc", OFS_GATE_SNAP, 16'h1B40);
    wreg(OFS_PFC_MIN_PULSE, 16'h03FF);
    wreg(OFS_PFC_DUTY, 16'h0100);
    n = 0;
    while (gate !== 1'b0 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    n = 0;
    while (s_off !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("sample_off_delay", 16'(n), 16'h0004);
    tk(2);
    hi_cnt(n);
    chk("short_pulse", 16'(n), 16'h0000);
    wreg(OFS_PFC_MIN_PULSE, 16'h0000);
    wreg(OFS_PFC_DUTY, DUTY_FULL);
  endtask : t_pwm
  task automatic t_fault(input logic [15:0] ta, input logic [15:0] pa, input logic [11:0] bad,
    input logic [11:0] hold, input logic [11:0] good, input bit sel);
    int n;
    // start healthy so persistence counts only from the bad sample on
    vac <= good;
    wreg(OFS_PFC_GATE_DLY, 16'h0000);
    wreg(OFS_BLANK_GAP, 16'h0080);
    wreg(OFS_AC_RESUME, 16'h0003);
    wreg(pa, 16'h0002);
    wreg(ta, 16'h0200);
    tk(2);
    vac <= bad;
    tk(2);
    chk("persist_early", 16'(sel ? uv : ov), 16'h0000);
    tk(1);
    chk("persist_done", 16'(sel ? uv : ov), 16'h0001);
    chk("fault_gate", 16'({run, gate}), 16'h0000);
    vac <= hold;
    tk(3);
    chk("flag_held", 16'(sel ? uv : ov), 16'h0001);
    vac <= good;
    n = 0;
    while (run !== 1'b1 && n < 12) begin
      tk(1);
      n++;
    end
    chk("resume_wait", 16'(n >= 4 && n <= 6), 16'h0001);
  endtask : t_fault
  task automatic t_blank();
    wreg(OFS_AC_UV_THR, 16'h0000);
    wreg(OFS_MIN_BLANK, 16'h0004);
    wreg(OFS_BLANK_DC_OFFSET, 16'h0010);
    dc <= 12'h400;
    // above the threshold only once the offset is subtracted
    vac <= 12'h178;
    tk(2);
    chk("blank_set", 16'({blank, gate}), 16'h0002);
    vac <= 12'h080;
    tk(3);
    chk("blank_hold", 16'(blank), 16'h0001);
    tk(4);
    chk("blank_clear", 16'(blank), 16'h0000);
    wreg(OFS_PFC_ENABLE, 16'h0000);
    tk(1);
    chk("stopped", 16'({run, gate}), 16'h0000);
  endtask : t_blank
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    fstep(12'hA00, 16'h0801);
    fstep(12'h601, 16'h0800);
    t_chan();
    t_pwm();
    t_fault(OFS_AC_OV_THR, OFS_AC_OV_TIME, 12'h300, 12'h1C0, 12'h100, 1'b0);
    wreg(OFS_AC_OV_THR, 16'h0FFF);
    t_fault(OFS_AC_UV_THR, OFS_AC_UV_TIME, 12'h100, 12'h1F0, 12'h300, 1'b1);
    t_blank();
    end_sim();
  end
endmodule : pfs_regs_tb
`default_nettype wire
